/* File: hw/tbl_cfg.svh */
// Purpose: constants for the transaction buffer file with loopback
// Assumes: 32-bit words, 4-bit buffer index
// Notes: offsets are byte addresses on the plain register port
`ifndef TBL_CFG_SVH
`define TBL_CFG_SVH
`define TBL_IDX_IO_CA 4'h0
`define TBL_IDX_IO_DATA 4'h1
`define TBL_IDX_A_CA 4'h3
`define TBL_IDX_A_LW1 4'h4
`define TBL_IDX_B_CA 4'hB
`define TBL_IDX_B_LW1 4'hC
`define TBL_REG_CTRL 8'h00
`define TBL_REG_STAT 8'h04
`define TBL_REG_MASK 8'h08
`define TBL_REG_INDEX 8'h0C
`define TBL_REG_TX_DATA 8'h10
`define TBL_REG_RX_DATA 8'h14
`define TBL_REG_SET_FAIL 8'h18
`define TBL_CTRL_SET_B 3
`define TBL_CTRL_FAIL_A 4
`define TBL_CTRL_FAIL_B 5
`define TBL_CTRL_OCTA 6
`define TBL_CTRL_LOOP_EN 7
`define TBL_CTRL_FLIP29 8
`define TBL_CTRL_FLIP1 9
`define TBL_ST_ILL_ADDR 0
`define TBL_ST_LOOP_DONE 1
`define TBL_ST_FATAL 2
`define TBL_ST_W 3
`define TBL_CTRL_W 10
`define TBL_RX_SECTION 4
`endif

/* File: hw/tbl_pkg.sv */
// Purpose: shared types for the transaction buffer file
// Assumes: nothing beyond the cfg header
// Notes: states of the loopback sequencer
package tbl_pkg;
  typedef enum logic [1:0] {TBL_IDLE, TBL_DMA, TBL_RET} tbl_state_t;
  typedef logic [31:0] tbl_word_t;
endpackage

/* File: hw/tbl_buf_if.sv */
// Purpose: access path between the sequencer and the buffer array
// Assumes: single clock
// Notes: one write port, one read port
`timescale 1ns/1ps
interface tbl_buf_if;
  logic we;
  logic rx_sel;
  logic [3:0] widx;
  logic [31:0] wdata;
  logic [3:0] ridx;
  logic rsel_rx;
  logic [31:0] rdata;
  modport ctl (output we, rx_sel, widx, wdata, ridx, rsel_rx, input rdata);
  modport mem (input we, rx_sel, widx, wdata, ridx, rsel_rx, output rdata);
endinterface

/* File: hw/tbl_buf_array.sv */
// Purpose: seventeen buffer words, transmit and receive sections
// Assumes: unmapped indices write nothing and read zero
// Notes: combinational read, registered write
`timescale 1ns/1ps
`include "tbl_cfg.svh"
module tbl_buf_array import tbl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Buffer access
  tbl_buf_if.mem bus
);
  tbl_word_t tx_ff [16];
  tbl_word_t rx_ff [8];

  // Only the documented slots exist; seventeen in all
  function automatic logic tx_valid(input logic [3:0] i);
    return i == `TBL_IDX_IO_DATA || (i >= `TBL_IDX_A_CA && i <= 4'h7) || i >= `TBL_IDX_B_CA; // RQ4
  endfunction
  function automatic logic rx_valid(input logic [3:0] i);
    return i == `TBL_IDX_IO_CA || i == `TBL_IDX_IO_DATA || (i >= `TBL_IDX_A_LW1 && i <= 4'h7); // RQ5
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 16; k++) tx_ff[k] <= 32'h0;
    end else if (bus.we && !bus.rx_sel && tx_valid(bus.widx)) begin
      tx_ff[bus.widx] <= bus.wdata; // RQ1
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 8; k++) rx_ff[k] <= 32'h0;
    end else if (bus.we && bus.rx_sel && rx_valid(bus.widx)) begin
      rx_ff[bus.widx[2:0]] <= bus.wdata; // RQ5
    end
  end

  always_comb begin
    bus.rdata = 32'h0;
    if (bus.rsel_rx) begin
      if (rx_valid(bus.ridx)) bus.rdata = rx_ff[bus.ridx[2:0]];
    end else if (tx_valid(bus.ridx)) begin
      bus.rdata = tx_ff[bus.ridx];
    end
  end
endmodule

/* File: hw/tbl_loopback.sv */
// Purpose: transaction buffer file with diagnostic loopback control
// Assumes: one clock; I/O requests come from the system bus side
// Notes: DMA set B takes over when set A is marked failed
// Behaviour
// RQ1: A buffer file of seventeen words is split into transmit and receive sections.
// RQ2: Two DMA sets A and B exist so a failed set is survivable; a failed I/O buffer is fatal.
// RQ3: DMA buffers are exercised in either loopback mode under the diagnostic control bits.
// RQ4: Transmit index 1 is I/O data, 3-7 set A, B-F set B command and data words.
// RQ5: Receive index 0 is I/O command, 1 I/O data, 4-7 set A data words.
// RQ6: Loopback enable turns off the drivers onto the internal adapter bus.
// RQ7: Loopback without the bit-29 flip raises an illegal address error.
// RQ8: The bit-29 flip turns I/O transactions into loopback DMA to memory.
// RQ9: The bit-1 flip, force-octaword and address bit 2 reach the wide data buffers.
// RQ10: The bit-1 flip only alters transmit data buffer accesses.
// RQ11: Returning DMA read words land in the receive buffers in arrival order.
// RQ12: The bit-1 flip leaves transmit command buffers alone.
// RQ13: Flip and address bit 2 both zero pick the first data word.
// RQ14: Force-octaword sends four words, masking all but the selected one.
// RQ15: In loopback one returned word answers the original I/O read.
// RQ16: Combinations 01, 10, 11 pick data words two, three and four.
// RQ17: Software sets the bit-29 flip in the same write as loopback enable.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "tbl_cfg.svh"
module tbl_loopback import tbl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // I/O request from the system bus
  input wire logic io_req,
  input wire logic io_write,
  input wire logic [31:0] io_addr,
  input wire logic [31:0] io_wdata,
  output logic io_done,
  output logic [31:0] io_rdata,
  // DMA toward system memory
  output logic dma_req,
  output logic dma_write,
  output logic dma_octa,
  output logic [31:0] dma_addr,
  output logic [3:0] dma_mask,
  output logic [127:0] dma_wdata,
  input wire logic dma_rvalid,
  input wire logic [31:0] dma_rword,
  input wire logic dma_done,
  // Internal adapter bus toward the downstream module
  output logic iab_oe,
  output logic [31:0] iab_out,
  output logic iab_valid,
  // Interrupt
  output logic irq
);
  tbl_buf_if bif();
  tbl_buf_array u_arr (
    .clk(clk),
    .rst_n(rst_n),
    .bus(bif)
  );

  logic [`TBL_CTRL_W-1:0] ctrl_ff;
  logic [`TBL_ST_W-1:0] stat_ff;
  logic [`TBL_ST_W-1:0] mask_ff;
  logic [4:0] index_ff;
  tbl_state_t state_ff;
  tbl_word_t io_addr_ff;
  logic [1:0] rx_cnt_ff;
  logic conv_evt;
  logic [31:0] reg_rdata_ff;
  logic [31:0] io_rdata_ff;
  logic io_done_ff;
  logic [127:0] dma_wdata_ff;
  logic [31:0] dma_addr_ff;
  logic [3:0] dma_mask_ff;
  logic dma_req_ff;
  logic dma_write_ff;
  logic dma_octa_ff;
  logic [31:0] iab_out_ff;
  logic iab_valid_ff;
  logic [1:0] lw_sel;
  logic use_b;
  logic loop_en;
  logic flip29;
  logic ill_evt;
  logic done_evt;
  logic [3:0] set_lw1;
  logic [3:0] set_ca;
  logic [`TBL_ST_W-1:0] set_bits;

  // Data word picked by the flip control and address bit 2
  function automatic logic [1:0] pick_lw(input logic flip, input logic a2);
    return {flip, a2}; // RQ13 RQ16
  endfunction

  assign loop_en = ctrl_ff[`TBL_CTRL_LOOP_EN];
  assign flip29 = ctrl_ff[`TBL_CTRL_FLIP29];
  assign use_b = ctrl_ff[`TBL_CTRL_SET_B] | ctrl_ff[`TBL_CTRL_FAIL_A]; // RQ2
  assign set_lw1 = use_b ? `TBL_IDX_B_LW1 : `TBL_IDX_A_LW1;
  assign set_ca = use_b ? `TBL_IDX_B_CA : `TBL_IDX_A_CA; // RQ12
  assign lw_sel = pick_lw(ctrl_ff[`TBL_CTRL_FLIP1], io_addr_ff[2]); // RQ9

  // Control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= '0;
    end else if (reg_wr && reg_addr == `TBL_REG_CTRL) begin
      ctrl_ff <= reg_wdata[`TBL_CTRL_W-1:0]; // RQ3
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= '0;
      index_ff <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `TBL_REG_MASK) mask_ff <= reg_wdata[`TBL_ST_W-1:0];
      if (reg_addr == `TBL_REG_INDEX) index_ff <= reg_wdata[4:0];
    end
  end

  // Loopback without the flip still decodes as I/O space
  assign ill_evt = (state_ff == TBL_IDLE) && io_req && loop_en && !flip29; // RQ7
  assign done_evt = (state_ff == TBL_RET);
  // Flip alone is the full DMA loopback; bus drivers stay on then
  assign conv_evt = (state_ff == TBL_IDLE) && io_req && flip29; // RQ8
  assign set_bits = {3'(0)} | ({2'b00, ill_evt} | {1'b0, done_evt, 1'b0});

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= (stat_ff & ~((reg_wr && reg_addr == `TBL_REG_STAT) ?
                  reg_wdata[`TBL_ST_W-1:0] : '0)) | set_bits;
      if (reg_wr && reg_addr == `TBL_REG_SET_FAIL && reg_wdata[0])
        stat_ff[`TBL_ST_FATAL] <= 1'b1; // RQ2
    end
  end
  assign irq = |(stat_ff & mask_ff);

  // Loopback sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= TBL_IDLE;
      io_addr_ff <= 32'h0;
      rx_cnt_ff <= 2'd0;
    end else begin
      unique case (state_ff)
        TBL_IDLE: begin
          if (conv_evt) begin
            state_ff <= TBL_DMA; // RQ8
            io_addr_ff <= io_addr;
            rx_cnt_ff <= 2'd0;
          end
        end
        TBL_DMA: begin
          if (dma_rvalid) rx_cnt_ff <= rx_cnt_ff + 2'd1; // RQ11
          if (dma_done) state_ff <= TBL_RET;
        end
        TBL_RET: state_ff <= TBL_IDLE;
      endcase
    end
  end

  // DMA request built from the incoming I/O request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_req_ff <= 1'b0;
      dma_write_ff <= 1'b0;
      dma_octa_ff <= 1'b0;
      dma_addr_ff <= 32'h0;
      dma_mask_ff <= 4'h0;
    end else begin
      dma_req_ff <= conv_evt;
      if (state_ff == TBL_IDLE && io_req) begin
        dma_write_ff <= io_write;
        dma_octa_ff <= ctrl_ff[`TBL_CTRL_OCTA]; // RQ14
        dma_addr_ff <= io_addr ^ 32'h2000_0000; // RQ8
        dma_mask_ff <= ctrl_ff[`TBL_CTRL_OCTA] ?
                       4'(1) << pick_lw(ctrl_ff[`TBL_CTRL_FLIP1], io_addr[2]) : 4'hF; // RQ14
      end
    end
  end

  // Write word copied to every slot; the mask picks what memory keeps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_wdata_ff <= '0;
    end else if (state_ff == TBL_IDLE && io_req) begin
      dma_wdata_ff <= {4{io_wdata}};
    end
  end

  // One returned word answers the original read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata_ff <= 32'h0;
    end else begin
      if (dma_rvalid && rx_cnt_ff == lw_sel) io_rdata_ff <= dma_rword; // RQ15
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_done_ff <= 1'b0;
    end else begin
      io_done_ff <= done_evt || ill_evt ||
                    ((state_ff == TBL_IDLE) && io_req && !loop_en && !flip29);
    end
  end

  // Normal path forwards I/O onto the internal bus; drivers off in loopback
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iab_out_ff <= 32'h0;
      iab_valid_ff <= 1'b0;
    end else begin
      iab_valid_ff <= io_req && !loop_en && !flip29 && (state_ff == TBL_IDLE); // RQ6
      if (io_req && !loop_en) iab_out_ff <= {io_addr[31:29], 4'h0, io_addr[24:0]};
    end
  end
  assign iab_oe = !loop_en; // RQ6

  // Buffer write path: returning words in order, then looped I/O requests, else software
  always_comb begin
    bif.we = 1'b0;
    bif.rx_sel = 1'b0;
    bif.widx = 4'h0;
    bif.wdata = reg_wdata;
    if (state_ff == TBL_DMA && dma_rvalid) begin
      bif.we = 1'b1;
      bif.rx_sel = 1'b1;
      bif.widx = `TBL_IDX_A_LW1 + {2'b00, rx_cnt_ff}; // RQ11 RQ10
      bif.wdata = dma_rword;
    end else if (conv_evt) begin
      bif.we = 1'b1;
      bif.widx = io_write ? set_lw1 + {2'b00, pick_lw(ctrl_ff[`TBL_CTRL_FLIP1], io_addr[2])}
                          : set_ca; // RQ9 RQ10
      bif.wdata = io_write ? io_wdata : io_addr;
    end else if (reg_wr && reg_addr == `TBL_REG_TX_DATA) begin
      bif.we = 1'b1;
      bif.rx_sel = index_ff[`TBL_RX_SECTION];
      bif.widx = index_ff[3:0];
    end
  end

  always_comb begin
    bif.ridx = index_ff[3:0];
    bif.rsel_rx = index_ff[`TBL_RX_SECTION];
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TBL_REG_CTRL: reg_rdata_ff <= {22'h0, ctrl_ff};
        `TBL_REG_STAT: reg_rdata_ff <= {29'h0, stat_ff};
        `TBL_REG_MASK: reg_rdata_ff <= {29'h0, mask_ff};
        `TBL_REG_INDEX: reg_rdata_ff <= {27'h0, index_ff};
        `TBL_REG_TX_DATA, `TBL_REG_RX_DATA: reg_rdata_ff <= bif.rdata;
        default: reg_rdata_ff <= 32'h0;
      endcase
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign io_rdata = io_rdata_ff;
  assign io_done = io_done_ff;
  assign dma_req = dma_req_ff;
  assign dma_write = dma_write_ff;
  assign dma_octa = dma_octa_ff;
  assign dma_addr = dma_addr_ff;
  assign dma_mask = dma_mask_ff;
  assign dma_wdata = dma_wdata_ff;
  assign iab_out = iab_out_ff;
  assign iab_valid = iab_valid_ff;
endmodule

/* File: test/tbl_mem_model.sv */
// Purpose: system memory answering the block's DMA requests
// Assumes: reads return two words, or four for octaword
// Notes: data lines show inverted junk outside valid words
`timescale 1ns/1ps
module tbl_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request from the block
  input wire logic dma_req,
  input wire logic dma_write,
  input wire logic dma_octa,
  // Knobs from the bench
  input wire logic [3:0] lat,
  input wire logic [31:0] seed,
  // Answer
  output logic dma_rvalid,
  output logic [31:0] dma_rword,
  output logic dma_done
);
  logic busy_ff;
  logic [3:0] wait_ff;
  logic [2:0] left_ff;
  logic [31:0] next_ff;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 0;
      dma_rvalid <= 0;
      dma_done <= 0;
      dma_rword <= 32'h0;
    end else begin
      dma_rvalid <= 0;
      dma_done <= 0;
      dma_rword <= ~dma_rword;
      if (dma_req) begin
        busy_ff <= 1;
        wait_ff <= lat;
        left_ff <= dma_write ? 3'h0 : (dma_octa ? 3'h4 : 3'h2);
        next_ff <= seed;
      end else if (busy_ff && wait_ff != 0) begin
        wait_ff <= wait_ff - 4'h1;
      end else if (busy_ff && left_ff != 0) begin
        dma_rvalid <= 1;
        dma_rword <= next_ff;
        next_ff <= next_ff + 32'h1;
        left_ff <= left_ff - 3'h1;
      end else if (busy_ff) begin
        dma_done <= 1;
        busy_ff <= 0;
      end
    end
  end
endmodule

/* File: test/tbl_loopback_checker.sv */
// Purpose: port-level checks on the loopback buffer file
// Assumes: control register shadowed from register writes
// Notes: mask bit n selects data word n+1
`timescale 1ns/1ps
`include "tbl_cfg.svh"
module tbl_loopback_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // I/O side
  input wire logic io_req,
  input wire logic [31:0] io_addr,
  input wire logic io_done,
  // DMA and internal bus
  input wire logic dma_req,
  input wire logic dma_octa,
  input wire logic [31:0] dma_addr,
  input wire logic [3:0] dma_mask,
  input wire logic dma_done,
  input wire logic iab_oe,
  input wire logic iab_valid
);
  logic [9:0] ctl_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff <= 10'h000;
    end else if (reg_wr && reg_addr == `TBL_REG_CTRL) begin
      ctl_ff <= reg_wdata[9:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_oe; iab_oe == !ctl_ff[7]; endproperty
  a_oe: assert property (p_oe) else $error("bus drivers enable wrong");
  property p_quiet; ctl_ff[7] |-> !iab_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("bus traffic in loopback");
  property p_ill; io_req && ctl_ff[7] && !ctl_ff[8] |=> io_done && !dma_req; endproperty
  a_ill: assert property (p_ill) else $error("illegal access not refused");
  property p_req; io_req && ctl_ff[8] |=> dma_req; endproperty
  a_req: assert property (p_req) else $error("no DMA for looped access");
  property p_flip; dma_req |-> dma_addr[29] != $past(io_addr[29]); endproperty
  a_flip: assert property (p_flip) else $error("address bit 29 not flipped");
  property p_octa; dma_req |-> dma_octa == ctl_ff[6]; endproperty
  a_octa: assert property (p_octa) else $error("DMA length wrong");
  property p_mask;
    dma_req |-> dma_mask == (dma_octa ? 4'h1 << {ctl_ff[9], $past(io_addr[2])} : 4'hF);
  endproperty
  a_mask: assert property (p_mask) else $error("DMA mask wrong");
  property p_done; dma_done |=> ##1 io_done; endproperty
  a_done: assert property (p_done) else $error("loopback read not answered");
  c_octa: cover property (dma_req && dma_octa);
  c_ill: cover property (io_req && ctl_ff[7] && !ctl_ff[8]);
  c_back: cover property (dma_done ##2 io_done);
endmodule
bind tbl_loopback tbl_loopback_checker chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .io_req, .io_addr, .io_done, .dma_req, .dma_octa, .dma_addr, .dma_mask, .dma_done,
  .iab_oe, .iab_valid);

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the loopback buffer file
// Assumes: memory model answers DMA after a random delay
// Notes: random data from a fixed-seed shift register
`timescale 1ns/1ps
`include "tbl_cfg.svh"
module tb_top import tbl_pkg::*;;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, io_req = 0, io_write = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, io_addr = 0, io_wdata = 0, mseed = 0, rnd = 32'hB34B;
  logic [3:0] mlat = 0, dma_mask;
  tbl_word_t reg_rdata, io_rdata, dma_addr, dma_rword, iab_out, d, s;
  logic [127:0] dma_wdata;
  logic io_done, dma_req, dma_write, dma_octa, dma_rvalid, dma_done, iab_oe, iab_valid, irq;
  logic got, saw;
  int n_fail = 0, n_compared = 0, cyc = 0;
  tbl_loopback uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .io_req, .io_write, .io_addr, .io_wdata, .io_done, .io_rdata, .dma_req, .dma_write,
    .dma_octa, .dma_addr, .dma_mask, .dma_wdata, .dma_rvalid, .dma_rword, .dma_done,
    .iab_oe, .iab_out, .iab_valid, .irq);
  tbl_mem_model mem (.clk, .rst_n, .dma_req, .dma_write, .dma_octa, .lat(mlat),
    .seed(mseed), .dma_rvalid, .dma_rword, .dma_done);
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic mapped(input logic [4:0] j);
    if (j[4]) return j[3:0] inside {4'h0, 4'h1, [4'h4:4'h7]};
    return j[3:0] inside {4'h1, [4'h3:4'h7], [4'hB:4'hF]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask
  task automatic io(input logic w, input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    io_req <= 1; io_write <= w; io_addr <= a; io_wdata <= v;
    got = 0; saw = 0;
    // Done may pulse right after the taking edge; look from that edge on
    repeat (100) if (!got) begin
      @(posedge clk);
      io_req <= 0;
      #1 saw |= (iab_valid === 1'b1);
      got = (io_done === 1'b1);
      s = io_rdata;
    end
    chk(got, 1);
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    #1 chk(iab_oe, 1);
    rd(`TBL_REG_CTRL, d);
    chk(d, 0);
    rd(`TBL_REG_STAT, d);
    chk(d, 0);
    rd(8'h1C, d);
    chk(d, 0);
    for (int j = 0; j < 32; j++) begin
      rnd = lfsr(rnd);
      wr(`TBL_REG_INDEX, j);
      wr(`TBL_REG_TX_DATA, rnd);
      rd(j[4] ? `TBL_REG_RX_DATA : `TBL_REG_TX_DATA, d);
      chk(d, mapped(j[4:0]) ? rnd : 32'h0);
    end
    // Both loopback modes, every word pick; quadword only reaches words one and two
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      mseed <= rnd; mlat <= rnd[7:4];
      wr(`TBL_REG_CTRL, {k[2] & k[1], 1'b1, rnd[8], k[2], 6'h00});
      io(1, {rnd[31:30], 1'b0, rnd[28:3], k[0], 2'b00}, ~rnd);
      chk(dma_wdata[{k[2] & k[1], k[0]} * 32 +: 32], ~rnd);
      io(0, {rnd[31:30], 1'b0, rnd[28:3], k[0], 2'b00}, 32'h0);
      chk(s, rnd + {k[2] & k[1], k[0]});
      chk(saw, 0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`TBL_REG_INDEX, 32'h14 + i);
      rd(`TBL_REG_RX_DATA, d); chk(d, rnd + i);
    end
    // Last write went to word four of set A, last read address to its command slot
    wr(`TBL_REG_INDEX, 32'h7);
    rd(`TBL_REG_TX_DATA, d);
    chk(d, ~rnd);
    wr(`TBL_REG_INDEX, 32'h3);
    rd(`TBL_REG_TX_DATA, d);
    chk(d, {rnd[31:30], 1'b0, rnd[28:3], 3'b100});
    // Set A marked failed: set B serves the looped write
    wr(`TBL_REG_CTRL, 32'h190);
    io(1, 32'h0000_0004, rnd);
    wr(`TBL_REG_INDEX, 32'hD);
    rd(`TBL_REG_TX_DATA, d);
    chk(d, rnd);
    rd(`TBL_REG_STAT, d); chk(d, 32'h2);
    wr(`TBL_REG_STAT, 32'h7);
    wr(`TBL_REG_MASK, 0);
    wr(`TBL_REG_CTRL, 32'h80);
    io(0, lfsr(rnd) & 32'hDFFF_FFFC, 0);
    #1 chk(irq, 0);
    chk(iab_oe, 0);
    wr(`TBL_REG_SET_FAIL, 1);
    rd(`TBL_REG_STAT, d); chk(d, 32'h5);
    wr(`TBL_REG_MASK, 1);
    #1 chk(irq, 1);
    wr(`TBL_REG_STAT, 32'h5);
    #1 chk(irq, 0);
    rd(`TBL_REG_STAT, d);
    chk(d, 0);
    wr(`TBL_REG_CTRL, 0);
    io(1, rnd & 32'hDFFF_FFFC, rnd);
    chk(saw, 1);
    chk(iab_out, rnd & 32'hC1FF_FFFC);
    end_of_test();
  end
endmodule
